//--- ebm_top.sv
module ebm_top #(
    parameter bit HAS_EPROM = 1'b0,
    parameter logic [ebm_pkg::EPROM_W-1:0] EPROM_RANGE_RST = ebm_pkg::EPROM_RANGE_RST
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic por_b_i,
    input wire logic hw_stop_i,
    input wire logic [ebm_pkg::REG_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire ebm_pkg::ebm_core_bus_t core_bus_i,
    input wire logic core_ram_sel_i,
    output logic ram_access_o,
    input wire logic [7:0] port_d_latch_i,
    output logic [7:0] port_d_in_o,
    input wire logic [7:0] port_f_latch_i,
    input wire logic [7:0] port_f_dir_i,
    output logic [7:0] port_f_in_o,
    input wire logic [7:0] port_d_pins_i,
    output logic [7:0] port_d_pins_o,
    output logic [7:0] port_d_pins_oe_o,
    input wire logic [7:0] port_f_pins_i,
    output logic [7:0] port_f_pins_o,
    output logic [7:0] port_f_pins_oe_o,
    output logic bus_ale_o,
    output logic bus_rd_b_o,
    output logic bus_wr_b_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ebm_pkg::ebm_mode_t mode;
        logic [ebm_pkg::EPROM_W-1:0] eprom;
        logic [7:0] rdata;
        logic [7:0] pd_out;
        logic [7:0] pd_oe;
        logic ale;
        logic rd_b;
        logic wr_b;
        logic ram_access;
    } ebm_state_t;

    localparam ebm_state_t STATE_RST = '{
        mode: ebm_pkg::ebm_mode_t'(ebm_pkg::MODE_RST),
        eprom: EPROM_RANGE_RST,
        rdata: 8'h00,
        pd_out: 8'h00,
        pd_oe: 8'h00,
        ale: 1'b0,
        rd_b: 1'b1,
        wr_b: 1'b1,
        ram_access: 1'b0
    };

    ebm_state_t state;
    ebm_state_t next_state;
    logic ram_access_enable;
    logic next_rae;
    logic reg_hit;
    logic expansion;
    logic [7:0] rd_word;
    logic [7:0] pf_addr_hi;

    assign reg_hit = (reg_addr_i == ebm_pkg::MMAP_CTRL_OFS);
    assign expansion = ebm_pkg::ebm_is_expansion(state.mode);

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    ebm_sync #(
        .W(8)
    ) u_sync_d (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i(port_d_pins_i),
        .sync_o(port_d_in_o)
    );

    ebm_sync #(
        .W(8)
    ) u_sync_f (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i(port_f_pins_i),
        .sync_o(port_f_in_o)
    );

    // ------------------------------------------------------------
    // port f address / general select
    // ------------------------------------------------------------
    // only the address bits of pins in address mode leave the chip, so the
    // high bits are masked simply by leaving those pins as ports
    assign pf_addr_hi = core_bus_i.addr[15:8];

    ebm_port_f_mux u_pf (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .mode_i(state.mode),
        .addr_hi_i(pf_addr_hi),
        .latch_i(port_f_latch_i),
        .dir_i(port_f_dir_i),
        .pins_o(port_f_pins_o),
        .pins_oe_o(port_f_pins_oe_o)
    );

    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    always_comb begin
        rd_word = 8'h00;
        rd_word[ebm_pkg::MODE_LSB +: ebm_pkg::MODE_W] = state.mode;
        rd_word[ebm_pkg::RAE_BIT] = ram_access_enable;
        if (HAS_EPROM) begin
            rd_word[ebm_pkg::EPROM_LSB +: ebm_pkg::EPROM_W] = state.eprom;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_rae = ram_access_enable;
        next_state.rdata = ebm_pkg::RDATA_UNMAPPED;
        if (reg_rd_i && reg_hit) begin
            next_state.rdata = rd_word;
        end
        if (reg_wr_i && reg_hit) begin
            // reserved encodings are stored as written
            next_state.mode = ebm_pkg::ebm_mode_t'(reg_wdata_i[ebm_pkg::MODE_LSB +:
                                                               ebm_pkg::MODE_W]);
            next_rae = reg_wdata_i[ebm_pkg::RAE_BIT];
            if (HAS_EPROM) begin
                next_state.eprom = reg_wdata_i[ebm_pkg::EPROM_LSB +: ebm_pkg::EPROM_W];
            end
        end
        // stop beats a same-cycle write to the mode and eprom fields so the bus cannot wake up driving
        if (hw_stop_i) begin
            next_state.mode = ebm_pkg::ebm_mode_t'(ebm_pkg::MODE_RST);
            next_state.eprom = EPROM_RANGE_RST;
        end

        next_state.ram_access = core_ram_sel_i && ram_access_enable;

        // port d: input, output latch, or multiplexed bus
        case (state.mode)
            ebm_pkg::EBM_SINGLE_IN: begin
                next_state.pd_oe = 8'h00;
                next_state.pd_out = 8'h00;
            end
            ebm_pkg::EBM_SINGLE_OUT: begin
                next_state.pd_oe = 8'hFF;
                next_state.pd_out = port_d_latch_i;
            end
            ebm_pkg::EBM_EXP_256, ebm_pkg::EBM_EXP_4K, ebm_pkg::EBM_EXP_16K,
            ebm_pkg::EBM_EXP_FULL: begin
                if (core_bus_i.ale) begin
                    next_state.pd_oe = 8'hFF;
                    next_state.pd_out = core_bus_i.addr[7:0];
                end else if (core_bus_i.mem_wr && core_bus_i.ext_sel) begin
                    next_state.pd_oe = 8'hFF;
                    next_state.pd_out = core_bus_i.wdata;
                end else begin
                    next_state.pd_oe = 8'h00;
                    next_state.pd_out = 8'h00;
                end
            end
            default: begin
                next_state.pd_oe = 8'h00;
                next_state.pd_out = 8'h00;
            end
        endcase

        // one memory strobe pair serves memory and peripherals alike
        next_state.ale = expansion && core_bus_i.ale;
        next_state.rd_b = !(expansion && core_bus_i.ext_sel && core_bus_i.mem_rd);
        next_state.wr_b = !(expansion && core_bus_i.ext_sel && core_bus_i.mem_wr);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= STATE_RST;
        end else begin
            state <= next_state;
        end
    end

    // the ram enable survives the ordinary reset; only power-on clears it,
    // and software is still expected to write it before use
    always_ff @(posedge clk_i or negedge por_b_i) begin
        if (!por_b_i) begin
            ram_access_enable <= ebm_pkg::RAE_POR;
        end else begin
            ram_access_enable <= next_rae;
        end
    end

    assign reg_rdata_o = state.rdata;
    assign ram_access_o = state.ram_access;
    assign port_d_pins_o = state.pd_out;
    assign port_d_pins_oe_o = state.pd_oe;
    assign bus_ale_o = state.ale;
    assign bus_rd_b_o = state.rd_b;
    assign bus_wr_b_o = state.wr_b;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    stop_clears_mode_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        hw_stop_i |=> (state.mode == ebm_pkg::EBM_SINGLE_IN) ##1 (port_d_pins_oe_o == 8'h00)
    ) else $error("mode not cleared by hardware stop");

    ram_gate_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i || !por_b_i)
        (core_ram_sel_i && !reg_rdata_o[ebm_pkg::RAE_BIT] && $past(reg_rd_i && reg_hit) &&
         !$past(reg_wr_i && reg_hit)) |=> !ram_access_o
    ) else $error("ram access passed while disabled");

    rae_hold_a: assert property (
        @(posedge clk_i) disable iff (!por_b_i)
        !(reg_wr_i && reg_hit) |=> $stable(ram_access_enable)
    ) else $error("ram enable changed without a write");

    pd_input_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state.mode == ebm_pkg::EBM_SINGLE_IN) [*2] |-> port_d_pins_oe_o == 8'h00
    ) else $error("port d driven in input mode");

    pd_output_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state.mode == ebm_pkg::EBM_SINGLE_OUT) |=>
            (port_d_pins_oe_o == 8'hFF) && (port_d_pins_o == $past(port_d_latch_i))
    ) else $error("port d output latch not on pins");

    pd_addr_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (expansion && core_bus_i.ale) |=>
            bus_ale_o && (port_d_pins_o == $past(core_bus_i.addr[7:0])) &&
            (port_d_pins_oe_o == 8'hFF)
    ) else $error("low address not on port d");

    pf_4k_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state.mode == ebm_pkg::EBM_EXP_4K) |=>
            (port_f_pins_oe_o[3:0] == 4'hF) && (port_f_pins_o[3:0] == $past(core_bus_i.addr[11:8]))
            && (port_f_pins_oe_o[7:4] == $past(port_f_dir_i[7:4]))
    ) else $error("4k port f split wrong");

    pf_16k_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state.mode == ebm_pkg::EBM_EXP_16K) |=>
            (port_f_pins_o[5:0] == $past(core_bus_i.addr[13:8])) &&
            (port_f_pins_oe_o[7:6] == $past(port_f_dir_i[7:6]))
    ) else $error("16k port f split wrong");

    pf_full_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (state.mode == ebm_pkg::EBM_EXP_FULL) |=>
            (port_f_pins_oe_o == 8'hFF) && (port_f_pins_o == $past(core_bus_i.addr[15:8]))
    ) else $error("full port f address wrong");

    strobe_idle_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (!expansion || !core_bus_i.ext_sel) |=> bus_rd_b_o && bus_wr_b_o
    ) else $error("strobe outside external memory cycle");

    upper_ignored_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (!HAS_EPROM) |-> (reg_rdata_o[7:4] == 4'h0)
    ) else $error("upper bits read nonzero without eprom");

endmodule

//--- ebm_pkg.sv
package ebm_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] MMAP_CTRL_OFS = 4'h0;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int RAE_BIT = 3;
    localparam int RSVD_BIT = 4;
    localparam int EPROM_LSB = 5;
    localparam int EPROM_W = 3;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [EPROM_W-1:0] EPROM_RANGE_RST = 3'h0;
    localparam logic RAE_POR = 1'h0;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // mode field encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EBM_SINGLE_IN  = 3'h0,
        EBM_SINGLE_OUT = 3'h1,
        EBM_EXP_256    = 3'h2,
        EBM_EXP_4K     = 3'h4,
        EBM_EXP_16K    = 3'h6,
        EBM_EXP_FULL   = 3'h7
    } ebm_mode_t;

    localparam logic [7:0] PF_MASK_NONE = 8'h00;
    localparam logic [7:0] PF_MASK_4K = 8'h0F;
    localparam logic [7:0] PF_MASK_16K = 8'h3F;
    localparam logic [7:0] PF_MASK_FULL = 8'hFF;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic ale;
        logic mem_rd;
        logic mem_wr;
        logic ext_sel;
    } ebm_core_bus_t;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    // reserved encodings (3 and 5) behave as no expansion at all
    function automatic logic ebm_is_expansion(input ebm_mode_t mode);
        ebm_is_expansion = (mode == EBM_EXP_256) || (mode == EBM_EXP_4K) ||
                           (mode == EBM_EXP_16K) || (mode == EBM_EXP_FULL);
    endfunction

    // port f pins that carry high address bits in each mode
    function automatic logic [7:0] ebm_addr_pin_mask(input ebm_mode_t mode);
        case (mode)
            EBM_EXP_4K: ebm_addr_pin_mask = PF_MASK_4K;
            EBM_EXP_16K: ebm_addr_pin_mask = PF_MASK_16K;
            EBM_EXP_FULL: ebm_addr_pin_mask = PF_MASK_FULL;
            default: ebm_addr_pin_mask = PF_MASK_NONE;
        endcase
    endfunction

endpackage

//--- ebm_sync.sv
module ebm_sync #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta;

    // meta is read by sync_o only
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

//--- ebm_port_f_mux.sv
module ebm_port_f_mux (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire ebm_pkg::ebm_mode_t mode_i,
    input wire logic [7:0] addr_hi_i,
    input wire logic [7:0] latch_i,
    input wire logic [7:0] dir_i,
    output logic [7:0] pins_o,
    output logic [7:0] pins_oe_o
);

    logic [7:0] addr_pin;

    assign addr_pin = ebm_pkg::ebm_addr_pin_mask(mode_i);

    // ------------------------------------------------------------
    // per-pin select
    // ------------------------------------------------------------
    // address pins drive in every machine cycle, not only memory cycles
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                pins_o[i] <= 1'b0;
                pins_oe_o[i] <= 1'b0;
            end else if (addr_pin[i]) begin
                pins_o[i] <= addr_hi_i[i];
                pins_oe_o[i] <= 1'b1;
            end else begin
                pins_o[i] <= latch_i[i];
                pins_oe_o[i] <= dir_i[i];
            end
        end
    end

endmodule

//--- ebm_mem_model.sv
module ebm_mem_model (
    input wire logic clk_i,
    input wire logic [7:0] port_d_i,
    input wire logic ale_i,
    input wire logic rd_b_i,
    input wire logic wr_b_i,
    output logic [7:0] port_d_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:255];
    logic [7:0] addr_lat = 8'h00;
    logic [7:0] idle = 8'h5A;

    // ------------------------------------------------------------
    // memory-mapped store
    // ------------------------------------------------------------
    // peripherals share the memory space, so one address latch decodes all
    always @(posedge clk_i) begin
        // a released bus must not hold its last value
        idle <= ~idle;
        if (ale_i) begin
            addr_lat <= port_d_i;
        end
        if (!wr_b_i) begin
            mem[addr_lat] <= port_d_i;
        end
    end

    assign port_d_o = !rd_b_i ? mem[addr_lat] : idle;
endmodule

//--- testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic por_b_i = 1'b0;
    logic hw_stop_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    ebm_pkg::ebm_core_bus_t cb = '0;
    logic core_ram_sel_i = 1'b0;
    logic ram_access_o;
    logic [7:0] pd_in, pf_in, pd_out, pd_oe, pf_out, pf_oe, pd_pins, pf_pins, mdl_pd;
    logic ale, rd_b, wr_b, found;
    logic [7:0] d;
    logic [7:0] rdata_e;
    // last two entries are the reserved encodings
    logic [2:0] modes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h3, 3'h5};
    logic [7:0] pfm [8] = '{8'h00, 8'h00, 8'h00, ebm_pkg::PF_MASK_4K, ebm_pkg::PF_MASK_16K,
                            ebm_pkg::PF_MASK_FULL, 8'h00, 8'h00};
    logic [7:0] pdx [8] = '{8'h00, 8'h96, 8'hC3, 8'hC3, 8'hC3, 8'hC3, 8'h00, 8'h00};
    int bad_count = 0;
    int check_count = 0;

    always #4 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    assign pd_pins = (pd_oe & pd_out) | (~pd_oe & mdl_pd);
    assign pf_pins = (pf_oe & pf_out) | (~pf_oe & 8'h3C);

    ebm_top ebm_top_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i), .hw_stop_i(hw_stop_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .core_bus_i(cb),
        .core_ram_sel_i(core_ram_sel_i), .ram_access_o(ram_access_o),
        .port_d_latch_i(8'h96), .port_d_in_o(pd_in), .port_f_latch_i(8'h81),
        .port_f_dir_i(8'h80), .port_f_in_o(pf_in), .port_d_pins_i(pd_pins),
        .port_d_pins_o(pd_out), .port_d_pins_oe_o(pd_oe), .port_f_pins_i(pf_pins),
        .port_f_pins_o(pf_out), .port_f_pins_oe_o(pf_oe), .bus_ale_o(ale),
        .bus_rd_b_o(rd_b), .bus_wr_b_o(wr_b)
    );

    // variant with the eprom range field, seen only through its readback
    ebm_top #(
        .HAS_EPROM(1'b1)
    ) ebm_top_eprom_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i), .hw_stop_i(hw_stop_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata_e), .core_bus_i(cb),
        .core_ram_sel_i(core_ram_sel_i), .ram_access_o(),
        .port_d_latch_i(8'h96), .port_d_in_o(), .port_f_latch_i(8'h81),
        .port_f_dir_i(8'h80), .port_f_in_o(), .port_d_pins_i(pd_pins),
        .port_d_pins_o(), .port_d_pins_oe_o(), .port_f_pins_i(pf_pins),
        .port_f_pins_o(), .port_f_pins_oe_o(), .bus_ale_o(),
        .bus_rd_b_o(), .bus_wr_b_o()
    );

    ebm_mem_model ebm_mem_model_inst (
        .clk_i(clk_i), .port_d_i(pd_pins), .ale_i(ale), .rd_b_i(rd_b), .wr_b_i(wr_b),
        .port_d_o(mdl_pd)
    );

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] wd);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= wd;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] rd);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rd = reg_rdata_o;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        por_b_i <= 1'b1;
        reg_read(4'h0, d);
        chk(d, 8'h00);
        chk(pd_oe, 8'h00);
        chk({6'h00, rd_b, wr_b}, 8'h03);
        reg_write(4'h5, 8'h07);
        reg_read(4'h0, d);
        chk(d, 8'h00);
        reg_read(4'h5, d);
        chk(d, 8'h00);
        reg_write(4'h0, 8'hFF);
        reg_read(4'h0, d);
        chk(d, 8'h0F);
        chk(rdata_e, 8'hEF);
        $display("test register map done");

        core_ram_sel_i <= 1'b1;
        reg_write(4'h0, 8'h08);
        @(posedge clk_i);
        #1;
        chk({7'h00, ram_access_o}, 8'h01);
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({7'h00, ram_access_o}, 8'h00);
        rst_b_i <= 1'b1;
        reg_read(4'h0, d);
        chk(d, 8'h08);
        chk({7'h00, ram_access_o}, 8'h01);
        // clearing before external memory is used, never mid-program
        reg_write(4'h0, 8'h00);
        @(posedge clk_i);
        #1;
        chk({7'h00, ram_access_o}, 8'h00);
        reg_read(4'h0, d);
        chk(d, 8'h00);
        reg_write(4'h0, 8'hEF);
        hw_stop_i <= 1'b1;
        @(posedge clk_i);
        hw_stop_i <= 1'b0;
        reg_read(4'h0, d);
        chk(d, 8'h08);
        chk(rdata_e, 8'h08);
        $display("test ram enable and reset done");

        cb.ale <= 1'b1;
        cb.ext_sel <= 1'b1;
        cb.addr <= 16'hA5C3;
        for (int i = 0; i < 8; i++) begin
            reg_write(4'h0, {5'h00, modes[i]});
            reg_read(4'h0, d);
            chk(d, {5'h00, modes[i]});
            @(posedge clk_i);
            #1;
            chk(pd_oe, (i == 0 || i > 5) ? 8'h00 : 8'hFF);
            chk(pd_out & pd_oe, pdx[i]);
            chk(pf_oe, pfm[i] | (8'h80 & ~pfm[i]));
            chk(pf_out & pfm[i], 8'hA5 & pfm[i]);
            chk(pf_in, (8'hA5 & pfm[i]) | (8'hBC & ~pfm[i]));
            chk({7'h00, ale}, (i > 1 && i < 6) ? 8'h01 : 8'h00);
            chk({6'h00, rd_b, wr_b}, 8'h03);
        end
        $display("test mode table done");

        reg_write(4'h0, 8'h07);
        cb.addr <= 16'h1234;
        @(posedge clk_i);
        #1;
        chk(pd_out, 8'h34);
        chk(pf_out, 8'h12);
        cb.ale <= 1'b0;
        cb.mem_wr <= 1'b1;
        cb.wdata <= 8'hAA;
        @(posedge clk_i);
        #1;
        chk({pd_out[6:0], wr_b}, 8'h54);
        cb.mem_wr <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(ebm_mem_model_inst.mem[8'h34], 8'hAA);
        cb.ale <= 1'b1;
        @(posedge clk_i);
        cb.ale <= 1'b0;
        cb.mem_rd <= 1'b1;
        @(posedge clk_i);
        #1;
        chk({pd_oe[6:0], rd_b}, 8'h00);
        found = 1'b0;
        for (int k = 0; k < 6 && !found; k++) begin
            @(posedge clk_i);
            #1;
            found = (pd_in === 8'hAA);
        end
        if (!found) begin
            bad_count++;
            $display("mismatch at %0t: read data never arrived", $time);
            end_sim();
        end
        cb.mem_rd <= 1'b0;
        $display("test external bus cycles done");
        end_sim();
    end
endmodule
